// File: verilog/ssp_status_port.sv
// Behaviour
// (R1) Status read at 3A9 or alternate 389
// (R2) Status readable anytime without disturbing operation
// (R3) Status bits match output pin meanings, except bit 0
// (R4) Bit 0 holding ready, ungated by CTS
// (R5) Ready pin needs CTS and transmit enable
// (R6) Bit 1 set when character waits
// (R7) Bit 2 one when transmitter empty
// (R8) Bit 3 sticky parity, cleared by reset
// (R9) Bit 4 set on unread overwritten character
// (R10) Overrun keeps receiving, old character lost
// (R11) Bit 5 unused, reads zero
// (R12) Bit 6 set on sync pattern found
// (R13) Double sync found mid last bit
// (R14) Bit 7 is inverted data-set-ready
// (R15) Transmitter ready and timers drive level 4
// (R16) Receiver ready drives level 3
// (R17) Host clears errors with command bit 4
// (R18) Host sets command bit 7 to hunt
// (R19) Host selects double sync with mode 0
// (R20) Status reads have no side effect on flags
`timescale 1ns/1ps
module ssp_status_port (
	input  wire logic       clk_sys_i,
	input  wire logic       reset_i,
	input  wire logic       ce_i,
	input  wire logic [9:0] io_addr_i,
	input  wire logic       io_rd_i,
	input  wire logic       io_wr_i,
	input  wire logic [7:0] io_wdata_i,
	output logic [7:0]      io_rdata_o,
	output logic            io_rvalid_o,
	input  wire logic       alt_sel_i,
	input  wire logic       rxd_i,
	input  wire logic       rxc_i,
	input  wire logic       txc_i,
	input  wire logic       cts_n_i,
	input  wire logic       dsr_n_i,
	input  wire logic       timer1_i,
	input  wire logic       timer2_i,
	output logic            txd_o,
	output logic            tx_ready_pin_o,
	output logic            tx_empty_pin_o,
	output logic            rx_ready_pin_o,
	output logic            sync_found_o,
	output logic            dtr_n_o,
	output logic            rts_n_o,
	output logic            irq3_o,
	output logic            irq4_o
);
	localparam int NS = 6;
	// Idle pin levels, so leaving reset shows no false clock edge
	localparam logic [NS-1:0] SYNC_IDLE = 6'h07;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [NS-1:0] s1_q, s2_q, s1_d;
	logic [1:0]    clk3_q;
	logic          rx_stb, tx_fall, cts_act, dsr_lo, alt_s, rxd_s;

	always_comb
	begin
		s1_d    = {alt_sel_i, dsr_n_i, cts_n_i, txc_i, rxc_i, rxd_i};
		rxd_s   = s2_q[0];
		rx_stb  = s2_q[1] & ~clk3_q[0];
		tx_fall = ~s2_q[2] & clk3_q[1];
		cts_act = ~s2_q[3];
		dsr_lo  = ~s2_q[4];
		alt_s   = s2_q[5];
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			s1_q   <= SYNC_IDLE;
			s2_q   <= SYNC_IDLE;
			clk3_q <= SYNC_IDLE[2:1];
		end
		else if (ce_i)
		begin
			s1_q   <= s1_d;
			s2_q   <= s1_q;
			clk3_q <= s2_q[2:1];
		end
	end

	// ----------------------------------------
	// Register state and flags
	// ----------------------------------------
	ssp_pkg::ssp_cfg_t cfg_q, cfg_d;
	logic [7:0] mode_q, mode_d, cmd_q, cmd_d, sy1_q, sy1_d, sy2_q, sy2_d;
	logic [7:0] rbuf_q, rbuf_d, hold_q, hold_d, rdat_d, stat;
	logic [8:0] shf_q, shf_d;
	logic [3:0] left_q, left_d, len;
	logic       full_q, full_d, rdy_q, rdy_d, par_q, par_d, ovr_q, ovr_d;
	logic       syf_q, syf_d, txd_d, pin_d, rv_d, hunt, erst;
	logic       c_stb, c_perr, found;
	logic [7:0] c_char, dmask;
	logic       sel_d, sel_c, rd_d, rd_s, wr_d, wr_c;

	always_comb
	begin
		len   = ssp_pkg::LEN_BASE + {2'b00, mode_q[ssp_pkg::MD_LEN +: 2]};
		dmask = 8'hff >> (4'h8 - len);
		// (R1) Decode, primary or alternate pair
		sel_d = io_addr_i == (alt_s ? ssp_pkg::REG_DATA_ALT : ssp_pkg::REG_DATA_PRI);
		sel_c = io_addr_i == (alt_s ? ssp_pkg::REG_CMD_ALT : ssp_pkg::REG_CMD_PRI);
		rd_d  = io_rd_i & sel_d;
		rd_s  = io_rd_i & sel_c;
		wr_d  = io_wr_i & sel_d;
		wr_c  = io_wr_i & sel_c;
		hunt  = wr_c && cfg_q == ssp_pkg::CFG_CMD && io_wdata_i[ssp_pkg::CMD_HUNT];
		erst  = wr_c && cfg_q == ssp_pkg::CFG_CMD && io_wdata_i[ssp_pkg::CMD_ERST];

		// (R3) Status built from the flags; bit 2 reads the empty pin flop, bit 7 the DSR synchroniser
		stat                   = 8'h00;
		// (R4) Holding ready, not gated
		stat[ssp_pkg::ST_TX_HOLDING_READY] = ~full_q;
		stat[ssp_pkg::ST_RX_CHAR_READY] = rdy_q;
		stat[ssp_pkg::ST_TXEMP] = tx_empty_pin_o;
		stat[ssp_pkg::ST_PERR]  = par_q;
		stat[ssp_pkg::ST_OVR]   = ovr_q;
		// (R11) Framing bit stays zero
		stat[ssp_pkg::ST_FRM]   = 1'b0;
		stat[ssp_pkg::ST_SYNC]  = syf_q;
		// (R14) Inverted data-set-ready
		stat[ssp_pkg::ST_DSR]   = dsr_lo;
	end

	ssp_rx_engine u_rx (
		.clk_sys_i  (clk_sys_i),
		.reset_i    (reset_i),
		.ce_i       (ce_i),
		.bit_stb_i  (rx_stb),
		.bit_i      (rxd_s),
		.hunt_i     (hunt),
		.len_i      (len),
		.pen_i      (mode_q[ssp_pkg::MD_PEN]),
		.even_i     (mode_q[ssp_pkg::MD_EVEN]),
		// (R19) Mode bit 7 low selects two sync characters
		.single_i   (mode_q[ssp_pkg::MD_SINGLE]),
		.sync1_i    (sy1_q),
		.sync2_i    (sy2_q),
		.char_stb_o (c_stb),
		.char_o     (c_char),
		.perr_o     (c_perr),
		.found_o    (found)
	);

	always_comb
	begin
		cfg_d  = cfg_q;
		mode_d = mode_q;
		cmd_d  = cmd_q;
		sy1_d  = sy1_q;
		sy2_d  = sy2_q;
		rbuf_d = rbuf_q;
		hold_d = hold_q;
		full_d = full_q;
		shf_d  = shf_q;
		left_d = left_q;
		rdy_d  = rdy_q;
		par_d  = par_q;
		ovr_d  = ovr_q;
		syf_d  = syf_q;
		txd_d  = txd_o;
		rv_d   = io_rd_i;
		rdat_d = io_rdata_o;

		// (R2) Status reads only copy state out
		if (io_rd_i)
			rdat_d = rd_d ? rbuf_q : (rd_s ? stat : ssp_pkg::RD_UNMAPPED);

		// Control writes walk mode, sync, then commands
		if (wr_c)
		begin
			case (cfg_q)
				ssp_pkg::CFG_MODE:
				begin
					mode_d = io_wdata_i;
					cfg_d  = io_wdata_i[ssp_pkg::MD_EXT] ? ssp_pkg::CFG_CMD : ssp_pkg::CFG_SYNC1;
				end
				ssp_pkg::CFG_SYNC1:
				begin
					sy1_d = io_wdata_i;
					cfg_d = mode_q[ssp_pkg::MD_SINGLE] ? ssp_pkg::CFG_CMD : ssp_pkg::CFG_SYNC2;
				end
				ssp_pkg::CFG_SYNC2:
				begin
					sy2_d = io_wdata_i;
					cfg_d = ssp_pkg::CFG_CMD;
				end
				ssp_pkg::CFG_CMD:
				begin
					cmd_d = io_wdata_i & ssp_pkg::CMD_KEEP;
					if (io_wdata_i[ssp_pkg::CMD_IRST])
					begin
						cmd_d = ssp_pkg::CMD_RST;
						cfg_d = ssp_pkg::CFG_MODE;
					end
				end
				default: cfg_d = ssp_pkg::CFG_MODE;
			endcase
		end

		// Error clear first so a same-cycle error wins
		// (R17) Error reset command clears both flags
		if (erst)
		begin
			par_d = 1'b0;
			ovr_d = 1'b0;
		end
		// (R18) Hunt command rearms sync search
		if (hunt)
			syf_d = 1'b0;
		// (R12) Sync flag sets on pattern
		if (found)
			syf_d = 1'b1;

		// (R20) Only the data read consumes a character
		if (rd_d)
			rdy_d = 1'b0;
		if (c_stb && cmd_q[ssp_pkg::CMD_RXEN])
		begin
			// (R9) Unread character overwritten
			if (rdy_q && !rd_d)
				ovr_d = 1'b1;
			// (R10) Newest kept, older one lost
			rbuf_d = c_char;
			// (R6) Character waiting
			rdy_d  = 1'b1;
			// (R8) Sticky until error reset
			if (c_perr)
				par_d = 1'b1;
		end

		// Transmitter: holding register feeds the shifter
		if (wr_d)
		begin
			hold_d = io_wdata_i;
			full_d = 1'b1;
		end
		if (tx_fall)
		begin
			if (left_q != 4'h0)
			begin
				txd_d  = shf_q[0];
				shf_d  = {1'b1, shf_q[8:1]};
				left_d = left_q - 4'h1;
			end
			else
				txd_d = 1'b1;
			if (cmd_q[ssp_pkg::CMD_BRK])
				txd_d = 1'b0;
		end
		// Load waits for CTS so a frame never starts unsent
		if (left_q == 4'h0 && full_q && !wr_d && cts_act && cmd_q[ssp_pkg::CMD_TXON])
		begin
			shf_d  = {1'b1, hold_q & dmask};
			shf_d[len] = (^(hold_q & dmask)) ^ ~mode_q[ssp_pkg::MD_EVEN];
			left_d = len + {3'b000, mode_q[ssp_pkg::MD_PEN]};
			full_d = 1'b0;
		end

		// (R5) Pin gated by CTS and transmit enable
		pin_d = ~full_d & cts_act & cmd_d[ssp_pkg::CMD_TXON];

		if (wr_c && cfg_q == ssp_pkg::CFG_CMD && io_wdata_i[ssp_pkg::CMD_IRST])
		begin
			full_d = 1'b0;
			left_d = 4'h0;
			rdy_d  = 1'b0;
			par_d  = 1'b0;
			ovr_d  = 1'b0;
			syf_d  = 1'b0;
			pin_d  = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			cfg_q          <= ssp_pkg::CFG_MODE;
			mode_q         <= ssp_pkg::MODE_RST;
			cmd_q          <= ssp_pkg::CMD_RST;
			sy1_q          <= 8'h00;
			sy2_q          <= 8'h00;
			rbuf_q         <= 8'h00;
			hold_q         <= 8'h00;
			full_q         <= 1'b0;
			shf_q          <= 9'h1ff;
			left_q         <= 4'h0;
			rdy_q          <= 1'b0;
			par_q          <= 1'b0;
			ovr_q          <= 1'b0;
			syf_q          <= 1'b0;
			txd_o          <= 1'b1;
			io_rdata_o     <= 8'h00;
			io_rvalid_o    <= 1'b0;
			tx_ready_pin_o <= 1'b0;
			tx_empty_pin_o <= 1'b1;
			rx_ready_pin_o <= 1'b0;
			sync_found_o   <= 1'b0;
			dtr_n_o        <= 1'b1;
			rts_n_o        <= 1'b1;
			irq3_o         <= 1'b0;
			irq4_o         <= 1'b0;
		end
		else if (ce_i)
		begin
			cfg_q          <= cfg_d;
			mode_q         <= mode_d;
			cmd_q          <= cmd_d;
			sy1_q          <= sy1_d;
			sy2_q          <= sy2_d;
			rbuf_q         <= rbuf_d;
			hold_q         <= hold_d;
			full_q         <= full_d;
			shf_q          <= shf_d;
			left_q         <= left_d;
			rdy_q          <= rdy_d;
			par_q          <= par_d;
			ovr_q          <= ovr_d;
			syf_q          <= syf_d;
			txd_o          <= txd_d;
			io_rdata_o     <= rdat_d;
			io_rvalid_o    <= rv_d;
			tx_ready_pin_o <= pin_d;
			// (R7) Empty when nothing held or shifting
			tx_empty_pin_o <= ~full_d & (left_d == 4'h0);
			rx_ready_pin_o <= rdy_d;
			sync_found_o   <= syf_d;
			dtr_n_o        <= ~cmd_d[ssp_pkg::CMD_DTR];
			rts_n_o        <= ~cmd_d[ssp_pkg::CMD_RTS];
			// (R16) Receiver ready on level 3
			irq3_o         <= rdy_d;
			// (R15) Transmitter ready and timers on level 4
			irq4_o         <= pin_d | timer1_i | timer2_i;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	property p_rd_keeps;
		(ce_i && rd_s && rdy_q) |=> rdy_q;
	endproperty
	a_rd_keeps: assert property (p_rd_keeps) else $error("status read lost rx ready"); // (R20)

	property p_bit0;
		(ce_i && rd_s) |=> io_rdata_o[ssp_pkg::ST_TX_HOLDING_READY] == $past(~full_q);
	endproperty
	a_bit0: assert property (p_bit0) else $error("status bit 0 wrong"); // (R4)

	property p_pin_gate;
		(ce_i && tx_ready_pin_o) |-> $past(cts_act && cmd_d[ssp_pkg::CMD_TXON]);
	endproperty
	a_pin_gate: assert property (p_pin_gate) else $error("ready pin without gating"); // (R5)

	property p_rx_set;
		(ce_i && c_stb && cmd_q[ssp_pkg::CMD_RXEN]) |=> rdy_q && irq3_o;
	endproperty
	a_rx_set: assert property (p_rx_set) else $error("char not flagged ready"); // (R6)

	property p_ovr;
		(ce_i && c_stb && cmd_q[ssp_pkg::CMD_RXEN] && rdy_q && !rd_d) |=> ovr_q;
	endproperty
	a_ovr: assert property (p_ovr) else $error("overrun not flagged"); // (R9)

	property p_par_sticky;
		(ce_i && par_q && !erst && !wr_c) |=> par_q;
	endproperty
	a_par_sticky: assert property (p_par_sticky) else $error("parity flag dropped"); // (R8)

	property p_dsr;
		(ce_i && rd_s) |=> io_rdata_o[ssp_pkg::ST_DSR] == $past(dsr_lo);
	endproperty
	a_dsr: assert property (p_dsr) else $error("dsr bit not inverted"); // (R14)

	property p_frm;
		(ce_i && rd_s) |=> !io_rdata_o[ssp_pkg::ST_FRM];
	endproperty
	a_frm: assert property (p_frm) else $error("framing bit set"); // (R11)

	property p_sync;
		(ce_i && found) |=> sync_found_o;
	endproperty
	a_sync: assert property (p_sync) else $error("sync found not reported"); // (R12)

endmodule // ssp_status_port

// File: verilog/ssp_pkg.sv
package ssp_pkg;

	// ----------------------------------------
	// Port map, primary and alternate
	// ----------------------------------------
	localparam int            AW          = 10;
	localparam logic [AW-1:0] REG_DATA_PRI = 10'h3a8;
	localparam logic [AW-1:0] REG_CMD_PRI  = 10'h3a9;
	localparam logic [AW-1:0] REG_DATA_ALT = 10'h388;
	localparam logic [AW-1:0] REG_CMD_ALT  = 10'h389;
	localparam logic [7:0]    RD_UNMAPPED  = 8'h00;

	// ----------------------------------------
	// Status word bits
	// ----------------------------------------
	localparam int ST_TX_HOLDING_READY = 0;
	localparam int ST_RX_CHAR_READY = 1;
	localparam int ST_TXEMP = 2;
	localparam int ST_PERR  = 3;
	localparam int ST_OVR   = 4;
	localparam int ST_FRM   = 5;
	localparam int ST_SYNC  = 6;
	localparam int ST_DSR   = 7;

	// ----------------------------------------
	// Command word bits
	// ----------------------------------------
	localparam int         CMD_TXON = 0;
	localparam int         CMD_DTR  = 1;
	localparam int         CMD_RXEN = 2;
	localparam int         CMD_BRK  = 3;
	localparam int         CMD_ERST = 4;
	localparam int         CMD_RTS  = 5;
	localparam int         CMD_IRST = 6;
	localparam int         CMD_HUNT = 7;
	localparam logic [7:0] CMD_RST  = 8'h00;
	localparam logic [7:0] CMD_KEEP = 8'h2f;

	// ----------------------------------------
	// Mode word fields
	// ----------------------------------------
	localparam int         MD_LEN    = 2;
	localparam int         MD_PEN    = 4;
	localparam int         MD_EVEN   = 5;
	localparam int         MD_EXT    = 6;
	localparam int         MD_SINGLE = 7;
	localparam logic [7:0] MODE_RST  = 8'h00;
	localparam logic [3:0] LEN_BASE  = 4'h5;

	typedef enum logic [1:0] {
		CFG_MODE  = 2'b00,
		CFG_SYNC1 = 2'b01,
		CFG_SYNC2 = 2'b10,
		CFG_CMD   = 2'b11
	} ssp_cfg_t;

	typedef enum logic [0:0] {
		RXE_HUNT = 1'b0,
		RXE_DATA = 1'b1
	} ssp_rxe_t;

endpackage

// File: verilog/ssp_rx_engine.sv
`timescale 1ns/1ps
module ssp_rx_engine (
	input  wire logic       clk_sys_i,
	input  wire logic       reset_i,
	input  wire logic       ce_i,
	input  wire logic       bit_stb_i,
	input  wire logic       bit_i,
	input  wire logic       hunt_i,
	input  wire logic [3:0] len_i,
	input  wire logic       pen_i,
	input  wire logic       even_i,
	input  wire logic       single_i,
	input  wire logic [7:0] sync1_i,
	input  wire logic [7:0] sync2_i,
	output logic            char_stb_o,
	output logic [7:0]      char_o,
	output logic            perr_o,
	output logic            found_o
);
	ssp_pkg::ssp_rxe_t st_q, st_d;
	logic [15:0] hist_q, hist_d;
	logic [4:0]  cnt_q, cnt_d;
	logic        stb_d, perr_d, found_d;
	logic [7:0]  char_d;
	logic [4:0]  win, frame;
	logic [15:0] got, exp_w, msk;

	always_comb
	begin
		st_d    = st_q;
		hist_d  = hist_q;
		cnt_d   = cnt_q;
		stb_d   = 1'b0;
		perr_d  = perr_o;
		found_d = 1'b0;
		char_d  = char_o;
		win     = single_i ? {1'b0, len_i} : {len_i, 1'b0};
		frame   = {1'b0, len_i} + {4'h0, pen_i};
		msk     = (16'h0001 << win) - 16'h0001;
		exp_w   = single_i ? {8'h00, sync1_i} : (({8'h00, sync2_i} << len_i) | {8'h00, sync1_i});
		got     = 16'h0000;
		if (hunt_i)
		begin
			st_d  = ssp_pkg::RXE_HUNT;
			cnt_d = 5'h00;
		end
		else if (bit_stb_i)
		begin
			hist_d = {bit_i, hist_q[15:1]};
			case (st_q)
				ssp_pkg::RXE_HUNT:
				begin
					if (cnt_q < win)
						cnt_d = cnt_q + 5'h01;
					got = hist_d >> (5'h10 - win);
					// (R13) Match on the last bit's mid sample
					if ((cnt_q + 5'h01 >= win) && ((got & msk) == (exp_w & msk)))
					begin
						found_d = 1'b1;
						st_d    = ssp_pkg::RXE_DATA;
						cnt_d   = 5'h00;
					end
				end
				ssp_pkg::RXE_DATA:
				begin
					cnt_d = cnt_q + 5'h01;
					if (cnt_q + 5'h01 == frame)
					begin
						got    = hist_d >> (5'h10 - frame);
						msk    = (16'h0001 << len_i) - 16'h0001;
						char_d = 8'((got & msk));
						perr_d = pen_i & ((^(got & ((msk << 1) | 16'h0001))) ^ ~even_i);
						stb_d  = 1'b1;
						cnt_d  = 5'h00;
					end
				end
				default: st_d = ssp_pkg::RXE_HUNT;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			st_q       <= ssp_pkg::RXE_HUNT;
			hist_q     <= 16'h0000;
			cnt_q      <= 5'h00;
			char_stb_o <= 1'b0;
			char_o     <= 8'h00;
			perr_o     <= 1'b0;
			found_o    <= 1'b0;
		end
		else if (ce_i)
		begin
			st_q       <= st_d;
			hist_q     <= hist_d;
			cnt_q      <= cnt_d;
			char_stb_o <= stb_d;
			char_o     <= char_d;
			perr_o     <= perr_d;
			found_o    <= found_d;
		end
	end

	// (R13) Found only follows a sampled bit
	property p_found_on_bit;
		@(posedge clk_sys_i) disable iff (reset_i)
		(ce_i && found_o) |-> $past(bit_stb_i);
	endproperty
	a_found_on_bit: assert property (p_found_on_bit) else $error("sync found without bit"); // (R13)

endmodule // ssp_rx_engine

// File: bench/ssp_host_model.sv
`timescale 1ns/1ps
module ssp_host_model (
	input  wire logic  clk_sys_i,
	output logic [9:0] io_addr_o,
	output logic       io_rd_o,
	output logic       io_wr_o,
	output logic [7:0] io_wdata_o
);
	initial
	begin
		io_addr_o  = 10'h000;
		io_rd_o    = 1'b0;
		io_wr_o    = 1'b0;
		io_wdata_o = 8'h00;
	end

	// ----------------------------------------
	// One bus cycle, read or write
	// ----------------------------------------
	// data or command port access
	task automatic xfer(input logic [9:0] a, input logic [7:0] d, input logic w);
		@(negedge clk_sys_i);
		io_addr_o  = a;
		io_wdata_o = d;
		io_wr_o    = w;
		io_rd_o    = ~w;
		// Held across exactly one rising edge
		@(negedge clk_sys_i);
		io_wr_o    = 1'b0;
		io_rd_o    = 1'b0;
		// Released lines must not look like the last value
		io_addr_o  = ~a;
		io_wdata_o = ~d;
	endtask
endmodule // ssp_host_model

// File: bench/sync_serial_status_port_tb.sv
`timescale 1ns/1ps
module sync_serial_status_port_tb;
	localparam logic [15:0] SYNC_PAIR = 16'h1632;
	logic       clk_sys_i;
	logic       reset_i;
	logic [9:0] io_addr;
	logic       io_rd;
	logic       io_wr;
	logic [7:0] io_wdata;
	logic [7:0] io_rdata;
	logic       io_rvalid;
	logic       alt_sel;
	logic       rxd;
	logic       rxc;
	logic       txc;
	logic       cts_n;
	logic       dsr_n;
	logic       timer1;
	logic       timer2;
	logic       txd;
	logic       tx_rdy;
	logic       tx_emp;
	logic       rx_rdy;
	logic       sync_f;
	logic       dtr_n;
	logic       rts_n;
	logic       irq3;
	logic       irq4;
	int         miscompares;
	int         num_checks;
	int         seed;
	int         i;
	logic [7:0] c;
	logic [7:0] exp_q[$];

	ssp_status_port ssp_status_port_i (
		.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(1'b1),
		.io_addr_i(io_addr), .io_rd_i(io_rd), .io_wr_i(io_wr), .io_wdata_i(io_wdata),
		.io_rdata_o(io_rdata), .io_rvalid_o(io_rvalid), .alt_sel_i(alt_sel),
		.rxd_i(rxd), .rxc_i(rxc), .txc_i(txc), .cts_n_i(cts_n), .dsr_n_i(dsr_n),
		.timer1_i(timer1), .timer2_i(timer2), .txd_o(txd), .tx_ready_pin_o(tx_rdy),
		.tx_empty_pin_o(tx_emp), .rx_ready_pin_o(rx_rdy), .sync_found_o(sync_f),
		.dtr_n_o(dtr_n), .rts_n_o(rts_n), .irq3_o(irq3), .irq4_o(irq4)
	);

	ssp_host_model ssp_host_model_i (
		.clk_sys_i(clk_sys_i), .io_addr_o(io_addr), .io_rd_o(io_rd),
		.io_wr_o(io_wr), .io_wdata_o(io_wdata)
	);

	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("checks=%0d mismatches=%0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Expected status; holding and shifter empty outside transmit
	function automatic logic [7:0] st(input logic rx, input logic pe, input logic ov,
			input logic sy);
		return {~dsr_n, sy, 1'b0, ov, pe, 1'b1, rx, 1'b1};
	endfunction

	always @(negedge clk_sys_i)
		if (io_rvalid === 1'b1)
		begin
			if (exp_q.size() == 0)
			begin
				miscompares++;
				$display("[ERR] t=%0t seen=%h exp=none", $time, io_rdata);
			end
			else
				chk(io_rdata, exp_q.pop_front());
		end

	// ----------------------------------------
	// Stimulus helpers
	// ----------------------------------------
	task automatic wt(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask

	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		ssp_host_model_i.xfer(a, 8'h00, 1'b0);
	endtask

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		ssp_host_model_i.xfer(a, d, 1'b1);
	endtask

	// Receive clock only moves inside frames
	task automatic bit_in(input logic b);
		rxd = b;
		rxc = 1'b0;
		wt(4);
		rxc = 1'b1;
		wt(4);
	endtask

	task automatic char_in(input logic [7:0] d, input logic bad);
		for (int k = 0; k < 8; k++)
			bit_in(d[k]);
		bit_in(^d ^ bad);
		rxd = ~rxd;
		wt(12);
	endtask

	initial
	begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end

	initial
	begin
		#400000;
		miscompares++;
		$display("[ERR] t=%0t seen=%h exp=%h", $time, 8'h00, 8'h01);
		close_out();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		seed = 32'hdaf5e1d3;
		reset_i = 1'b1;
		alt_sel = 1'b0;
		rxd = 1'b1;
		rxc = 1'b1;
		txc = 1'b1;
		cts_n = 1'b0;
		dsr_n = 1'b0;
		timer1 = 1'b0;
		timer2 = 1'b0;
		wt(6);
		reset_i = 1'b0;
		wt(4);
		rd(ssp_pkg::REG_CMD_PRI, st(0, 0, 0, 0));
		rd(10'h3a0, ssp_pkg::RD_UNMAPPED);
		chk({6'h00, tx_emp, irq3}, 8'h02);
		dsr_n = 1'b1;
		wt(4);
		rd(ssp_pkg::REG_CMD_PRI, st(0, 0, 0, 0));
		dsr_n = 1'b0;
		wt(4);
		// Eight bits, even parity, two sync characters
		wr(ssp_pkg::REG_CMD_PRI, 8'h3c);
		wr(ssp_pkg::REG_CMD_PRI, SYNC_PAIR[7:0]);
		wr(ssp_pkg::REG_CMD_PRI, SYNC_PAIR[15:8]);
		wr(ssp_pkg::REG_CMD_PRI, 8'ha6);
		wt(6);
		chk({6'h00, dtr_n, rts_n}, 8'h00);
		chk({7'h00, tx_rdy}, 8'h00);
		rd(ssp_pkg::REG_CMD_PRI, st(0, 0, 0, 0));
		for (i = 0; i < 3; i++)
			bit_in(1'b1);
		for (i = 0; i < 15; i++)
			bit_in(SYNC_PAIR[i]);
		chk({7'h00, sync_f}, 8'h00);
		bit_in(SYNC_PAIR[15]);
		wt(6);
		chk({7'h00, sync_f}, 8'h01);
		rd(ssp_pkg::REG_CMD_PRI, st(0, 0, 0, 1));
		c = 8'($random(seed));
		char_in(c, 1'b0);
		chk({6'h00, irq3, rx_rdy}, 8'h03);
		rd(ssp_pkg::REG_CMD_PRI, st(1, 0, 0, 1));
		rd(ssp_pkg::REG_CMD_PRI, st(1, 0, 0, 1));
		rd(ssp_pkg::REG_DATA_PRI, c);
		rd(ssp_pkg::REG_CMD_PRI, st(0, 0, 0, 1));
		// Two characters unread, the older one is lost
		c = 8'($random(seed));
		char_in(c, 1'b0);
		c = 8'($random(seed));
		char_in(c, 1'b0);
		rd(ssp_pkg::REG_CMD_PRI, st(1, 0, 1, 1));
		rd(ssp_pkg::REG_DATA_PRI, c);
		c = 8'($random(seed));
		char_in(c, 1'b1);
		rd(ssp_pkg::REG_CMD_PRI, st(1, 1, 1, 1));
		rd(ssp_pkg::REG_DATA_PRI, c);
		rd(ssp_pkg::REG_CMD_PRI, st(0, 1, 1, 1));
		// Error reset together with transmit on
		wr(ssp_pkg::REG_CMD_PRI, 8'h37);
		wt(6);
		rd(ssp_pkg::REG_CMD_PRI, st(0, 0, 0, 1));
		chk({6'h00, irq4, tx_rdy}, 8'h03);
		cts_n = 1'b1;
		wt(8);
		chk({6'h00, irq4, tx_rdy}, 8'h00);
		rd(ssp_pkg::REG_CMD_PRI, st(0, 0, 0, 1));
		for (i = 0; i < 2; i++)
		begin
			{timer2, timer1} = 2'b01 << i;
			wt(3);
			chk({7'h00, irq4}, 8'h01);
		end
		{timer2, timer1} = 2'b00;
		cts_n = 1'b0;
		wt(8);
		c = 8'($random(seed));
		wr(ssp_pkg::REG_DATA_PRI, c);
		wt(4);
		for (i = 0; i < 9; i++)
		begin
			txc = 1'b0;
			wt(6);
			chk({7'h00, txd}, {7'h00, (i < 8) ? c[i] : ^c});
			if (i < 8)
				chk({7'h00, tx_emp}, 8'h00);
			txc = 1'b1;
			wt(4);
		end
		for (i = 0; i < 2; i++)
		begin
			txc = 1'b0;
			wt(4);
			txc = 1'b1;
			wt(4);
		end
		wt(4);
		chk({7'h00, tx_emp}, 8'h01);
		alt_sel = 1'b1;
		wt(4);
		rd(ssp_pkg::REG_CMD_ALT, st(0, 0, 0, 1));
		rd(ssp_pkg::REG_CMD_PRI, ssp_pkg::RD_UNMAPPED);
		wt(4);
		close_out();
	end
endmodule // sync_serial_status_port_tb
